// ---- src/ccr_apb_regs.sv ----
// APB register slave holding the power management control word
`timescale 1ns/100ps
module ccr_apb_regs import ccr_pkg::*; (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	ccr_cfg_if.regs cfg
);
	// Address decode
	wire logic hit_ctrl = (paddr_i == ADDR_CTRL);
	wire logic hit_stat = (paddr_i == ADDR_STAT);
	wire logic mapped = hit_ctrl | hit_stat;
	// Writes are ignored while reset holds the straps in charge
	wire logic wr_ctrl = psel_i & penable_i & pwrite_i & hit_ctrl & ~sys_rst_i;
	wire logic setup_rd = psel_i & ~penable_i & ~pwrite_i;
	// Read words, reserved bits zero
	wire logic [31:0] ctrl_word = (32'(cfg.sw_mult) << MULT_LSB)
		| (32'(cfg.sw_div) << DIV_LSB) | (32'(cfg.sw_halve) << HALVE_BIT);
	wire logic [31:0] stat_word = (32'(cfg.eff_mult) << MULT_LSB)
		| (32'(cfg.applied_div) << DIV_LSB) | (32'(cfg.halve_cur) << HALVE_BIT)
		| (32'(cfg.locked) << LOCK_BIT);
	wire logic [31:0] rd_word = hit_ctrl ? ctrl_word : (hit_stat ? stat_word : 32'h0);

	// Zero wait states; unmapped addresses answer with an error
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~mapped;

	// Read data captured in setup so it stands through the access phase
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			prdata_o <= 32'h0;
		end else if (setup_rd) begin
			prdata_o <= rd_word;
		end
	end

	// Control fields; the multiplier field follows the straps during reset
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			cfg.sw_mult <= cfg.strap_mult;
			cfg.sw_div <= DIV_RESET;
			cfg.sw_halve <= HALVE_RESET;
		end else if (wr_ctrl) begin
			cfg.sw_mult <= pwdata_i[MULT_LSB +: MULT_W];
			cfg.sw_div <= pwdata_i[DIV_LSB +: DIVC_W];
			cfg.sw_halve <= pwdata_i[HALVE_BIT];
		end
	end
endmodule

// ---- src/ccr_cfg_if.sv ----
// Settings and status passed between the clock ratio modules
`timescale 1ns/100ps
interface ccr_cfg_if;
	import ccr_pkg::*;
	ccr_mult_type sw_mult;     // Software multiplier field
	ccr_divc_type sw_div;      // Software divider code
	logic sw_halve;            // Software input halving enable
	ccr_mult_type strap_mult;  // Multiplier from strap pins
	ccr_mult_type eff_mult;    // Multiplier in effect
	ccr_divc_type eff_div;     // Divider code requested
	ccr_divc_type applied_div; // Divider code the generator runs
	logic halve_cur;           // Halving stage in effect
	logic locked;              // Lock wait finished
	modport regs (output sw_mult, output sw_div, output sw_halve, input strap_mult,
		input eff_mult, input applied_div, input halve_cur, input locked);
	modport clkgen (input eff_div, output applied_div);
endinterface

// ---- src/ccr_clk_gen.sv ----
// Glitch-free post divider producing core and peripheral clocks
`timescale 1ns/100ps
module ccr_clk_gen import ccr_pkg::*; (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	ccr_cfg_if.clkgen cfg,
	output logic core_clk_o,
	output logic periph_clk_o
);
	logic [2:0] phase_cnt;  // Oscillator cycles within a half period
	ccr_divc_type cur_div;  // Divider code now running
	// Half period is the divider value in oscillator cycles
	wire logic [2:0] phase_last = 3'((4'h1 << cur_div) - 4'h1);
	wire logic at_last = (phase_cnt == phase_last);
	// A new code is taken only as the core clock falls, so no phase is cut
	wire logic swap = at_last & core_clk_o;
	wire logic core_rise = at_last & ~core_clk_o;

	// Half-period counter and code swap
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			phase_cnt <= 3'h0;
			cur_div <= DIV_RESET;
		end else begin
			phase_cnt <= at_last ? 3'h0 : phase_cnt + 3'h1;
			if (swap) begin
				cur_div <= cfg.eff_div;
			end
		end
	end

	// Core clock toggles each half period; peripheral toggles on core rise
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			core_clk_o <= 1'b0;
			periph_clk_o <= 1'b0;
		end else begin
			core_clk_o <= at_last ? ~core_clk_o : core_clk_o;
			periph_clk_o <= core_rise ? ~periph_clk_o : periph_clk_o;
		end
	end

	assign cfg.applied_div = cur_div;
endmodule

// ---- src/ccr_pkg.sv ----
// Shared constants and types for the core clock ratio block
package ccr_pkg;
	// Field widths of the multiplier and divider codes
	localparam int MULT_W = 6;
	localparam int DIVC_W = 2;
	typedef logic [MULT_W-1:0] ccr_mult_type;
	typedef logic [DIVC_W-1:0] ccr_divc_type;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	// Field positions, common to control and status words except the lock bit, which only the status word holds
	localparam int MULT_LSB = 0;
	localparam int DIV_LSB = 8;
	localparam int HALVE_BIT = 12;
	localparam int LOCK_BIT = 16;
	// Values after reset
	localparam ccr_divc_type DIV_RESET = 2'h0;
	localparam logic HALVE_RESET = 1'b0;
	// Multiplier picked by each strap code
	localparam ccr_mult_type STRAP_MULT_0 = 6'h08;
	localparam ccr_mult_type STRAP_MULT_1 = 6'h10;
	localparam ccr_mult_type STRAP_MULT_2 = 6'h18;
	localparam ccr_mult_type STRAP_MULT_3 = 6'h20;
	// Reference cycles waited for loop lock after reset
	localparam int LOCK_REF_CYCLES = 4096;
	localparam int LOCK_CNT_W = 13;
	// Lock sequencer states, one-hot
	typedef enum logic [2:0] {
		ST_HOLD = 3'h1,
		ST_LOCKING = 3'h2,
		ST_RUN = 3'h4
	} ccr_lock_type;
endpackage

// ---- src/ccr_top.sv ----
// Core clock ratio control: straps, halving, ratios, lock wait, divider
`timescale 1ns/100ps

// Overview of operation
// - Straps pick the multiplier while reset holds
// - Ratio set by straps or control register
// - Loop input is reference, or half it
// - Oscillator runs at twice multiplier times input
// - Core clock is oscillator over twice divider
// - Reset forces the divider value to one
// - Peripheral clock period is twice core period
// - Core clock drives memory, core, serial ports
// - Wait 4096 reference cycles before core runs
module ccr_top import ccr_pkg::*; #(
	parameter int LOCK_CYCLES = LOCK_REF_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic reference_clock_in_i,
	input wire logic [1:0] clock_ratio_strap_pins_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic core_clk_o,
	output logic periph_clk_o,
	output logic loop_input_tick_o,
	output logic [MULT_W:0] vco_ratio_o,
	output logic [4:0] core_divisor_o,
	output logic core_run_o
);
	// Last count of the lock wait
	localparam logic [LOCK_CNT_W-1:0] LOCK_LAST = LOCK_CNT_W'(LOCK_CYCLES - 1);

	// Settings and status shared with the register and divider modules
	ccr_cfg_if cfg();

	// Pin synchronisers; the first stage feeds only the second
	logic ref_meta;
	logic ref_sync;
	logic ref_prev;          // Previous synchronised reference level
	logic [1:0] strap_meta;
	logic [1:0] strap_sync;

	// Input halving stage
	logic halve_cur;         // Halving in effect
	logic halve_phase;       // Odd reference edge seen while halving

	// Lock wait
	ccr_lock_type lock_state;
	logic [LOCK_CNT_W-1:0] lock_cnt;

	// Two flops on the reference and strap pins before any logic looks at them
	always_ff @(posedge clk_sys_i) begin
		ref_meta <= reference_clock_in_i;
		ref_sync <= ref_meta;
		ref_prev <= ref_sync;
		strap_meta <= clock_ratio_strap_pins_i;
		strap_sync <= strap_meta;
	end

	// Rising reference edge, one cycle wide
	wire logic ref_rise = ref_sync & ~ref_prev;

	// Strap code to multiplier
	wire ccr_mult_type strap_mult = (strap_sync == 2'h0) ? STRAP_MULT_0 :
		(strap_sync == 2'h1) ? STRAP_MULT_1 :
		(strap_sync == 2'h2) ? STRAP_MULT_2 : STRAP_MULT_3;
	assign cfg.strap_mult = strap_mult;

	assign cfg.eff_mult = sys_rst_i ? strap_mult : cfg.sw_mult;

	assign cfg.eff_div = sys_rst_i ? DIV_RESET : cfg.sw_div;

	wire logic loop_tick = ref_rise & (~halve_cur | halve_phase);

	// Halving stage; a new setting is taken only on a loop input edge,
	// so the loop never sees a shortened input period
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			halve_cur <= HALVE_RESET;
			halve_phase <= 1'b0;
		end else if (loop_tick) begin
			halve_cur <= cfg.sw_halve;
			halve_phase <= 1'b0;
		end else if (ref_rise) begin
			// Odd edge while halving, no loop input edge
			halve_phase <= 1'b1;
		end
	end
	assign cfg.halve_cur = halve_cur;

	// Ratio outputs, registered
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			loop_input_tick_o <= 1'b0;
			vco_ratio_o <= '0;
			core_divisor_o <= 5'h2;
		end else begin
			loop_input_tick_o <= loop_tick;
			vco_ratio_o <= {cfg.eff_mult, 1'b0};
			core_divisor_o <= 5'(5'h2 << cfg.applied_div);
		end
	end

	// Lock wait sequencer; counts reference edges, not system cycles,
	// so the wait tracks the reference whatever its rate
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			lock_state <= ST_HOLD;
			lock_cnt <= '0;
			core_run_o <= 1'b0;
		end else begin
			case (lock_state)
				ST_HOLD: begin
					// First cycle after release
					lock_state <= ST_LOCKING;
				end
				ST_LOCKING: begin
					if (ref_rise && lock_cnt == LOCK_LAST) begin
						lock_state <= ST_RUN;
						core_run_o <= 1'b1;
					end else if (ref_rise) begin
						lock_cnt <= lock_cnt + 1'b1;
					end
				end
				ST_RUN: begin
					// Stays until the next reset
					core_run_o <= 1'b1;
				end
				default: begin
					lock_state <= ST_HOLD;
				end
			endcase
		end
	end
	assign cfg.locked = core_run_o;

	// Register slave
	ccr_apb_regs u_regs (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.psel_i(psel_i),
		.penable_i(penable_i),
		.pwrite_i(pwrite_i),
		.paddr_i(paddr_i),
		.pwdata_i(pwdata_i),
		.prdata_o(prdata_o),
		.pready_o(pready_o),
		.pslverr_o(pslverr_o),
		.cfg(cfg.regs)
	);

	ccr_clk_gen u_clk_gen (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.cfg(cfg.clkgen),
		.core_clk_o(core_clk_o),
		.periph_clk_o(periph_clk_o)
	);

	// Checks below run on the system clock and sleep during reset, except a_reset_div_one and a_reset_quiet
	default clocking cb_sys @(posedge clk_sys_i);
	endclocking
	default disable iff (sys_rst_i);

	a_strap_at_release: assert property (
		$fell(sys_rst_i) |-> cfg.sw_mult == $past(strap_mult))
		else $error("multiplier field lost the strap value at reset release");

	a_sw_write_apply: assert property (
		psel_i && penable_i && pwrite_i && paddr_i == ADDR_CTRL
		|=> cfg.eff_mult == $past(pwdata_i[MULT_LSB +: MULT_W])
		&& cfg.eff_div == $past(pwdata_i[DIV_LSB +: DIVC_W]))
		else $error("control write did not reach the effective settings");

	a_halve_skip: assert property (
		ref_rise && halve_cur && !halve_phase |=> !loop_input_tick_o)
		else $error("loop input ticked on a skipped reference edge");

	a_direct_tick: assert property (
		ref_rise && !halve_cur |=> loop_input_tick_o)
		else $error("loop input missed a reference edge");

	a_vco_ratio: assert property (
		1'b1 |=> vco_ratio_o == {$past(cfg.eff_mult), 1'b0})
		else $error("oscillator ratio is not twice the multiplier");

	a_core_high_div4: assert property (
		$rose(core_clk_o) && cfg.applied_div == 2'h2
		|-> core_clk_o [*4] ##1 !core_clk_o)
		else $error("core high phase is not four oscillator cycles");

	a_reset_div_one: assert property (
		@(posedge clk_sys_i) disable iff (1'b0)
		sys_rst_i [*2] |-> cfg.applied_div == DIV_RESET && cfg.eff_div == DIV_RESET)
		else $error("divider not forced to one during reset");

	a_periph_on_rise: assert property (
		$changed(periph_clk_o) == $rose(core_clk_o))
		else $error("peripheral clock not toggling on each core rise");

	a_core_toggles: assert property (
		!sys_rst_i |-> ##[0:8] $changed(core_clk_o))
		else $error("core clock stalled");

	a_lock_count: assert property (
		$rose(core_run_o) |-> $past(lock_cnt) == LOCK_LAST && $past(ref_rise))
		else $error("core started before the lock wait ended");

	a_div_swap_fall: assert property (
		$changed(cfg.applied_div) |-> $fell(core_clk_o))
		else $error("divider changed away from a core falling edge");

	a_halve_swap: assert property (
		$changed(halve_cur) |-> $past(loop_tick))
		else $error("halving changed between loop input edges");

	// The checks below, with a_core_high_div4 above, pin down every divider code, not only one,
	// so a wrong shift in the half-period counter cannot hide

	a_core_high_div1: assert property (
		$rose(core_clk_o) && cfg.applied_div == 2'h0 |-> ##1 !core_clk_o)
		else $error("core high phase is not one oscillator cycle");

	a_core_low_div2: assert property (
		$fell(core_clk_o) && cfg.applied_div == 2'h1
		|-> !core_clk_o [*2] ##1 core_clk_o)
		else $error("core low phase is not two oscillator cycles");

	a_core_high_div8: assert property (
		$rose(core_clk_o) && cfg.applied_div == 2'h3
		|-> core_clk_o [*8] ##1 !core_clk_o)
		else $error("core high phase is not eight oscillator cycles");

	a_core_divisor: assert property (
		1'b1 |=> core_divisor_o == 5'(5'h2 << $past(cfg.applied_div)))
		else $error("reported core divisor is not twice the divider value");

	// tick lasts one cycle
	// A reference edge is a single cycle wide, so the tick must be too
	a_tick_pulse: assert property (
		loop_input_tick_o |=> !loop_input_tick_o)
		else $error("loop input tick stretched beyond one cycle");

	a_run_state: assert property (
		core_run_o == (lock_state == ST_RUN))
		else $error("core run flag disagrees with the lock sequencer");

	// run never drops
	// Only a reset may stop the core once the lock wait has ended
	a_run_holds: assert property (
		core_run_o |=> core_run_o)
		else $error("core run flag dropped without a reset");

	// outputs quiet in reset
	// Held reset must keep both clocks and the run flag low
	a_reset_quiet: assert property (
		@(posedge clk_sys_i) disable iff (1'b0)
		sys_rst_i [*2] |-> !core_clk_o && !periph_clk_o && !core_run_o
		&& vco_ratio_o == '0)
		else $error("clock outputs active while reset is held");

	a_bus_error_map: assert property (
		psel_i && penable_i
		|-> pslverr_o == (paddr_i != ADDR_CTRL && paddr_i != ADDR_STAT))
		else $error("bus error does not match the register map");

	a_bus_ready: assert property (
		psel_i && penable_i |-> pready_o)
		else $error("register slave inserted a wait state");
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the core clock ratio block
`timescale 1ns/100ps
module tb;
	import ccr_pkg::*;
	localparam int LOCK_SIM = 8; // Short lock wait keeps the run brief
	typedef struct {logic [31:0] data; logic err;} ccr_note_type;
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic ref_pin = 1'b0; // Reference clock pin, period eight system cycles
	logic [1:0] straps = 2'h0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata_o;
	logic pready_o, pslverr_o, core_clk_o, periph_clk_o, loop_input_tick_o, core_run_o;
	logic [MULT_W:0] vco_ratio_o;
	logic [4:0] core_divisor_o;
	int err_count = 0, samples_checked = 0, ref_rises = 0, rdiv = 0;
	ccr_note_type exp_q[$]; // Expected read answers, oldest first
	ccr_top #(.LOCK_CYCLES(LOCK_SIM)) dut_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.reference_clock_in_i(ref_pin), .clock_ratio_strap_pins_i(straps), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.core_clk_o(core_clk_o), .periph_clk_o(periph_clk_o),
		.loop_input_tick_o(loop_input_tick_o), .vco_ratio_o(vco_ratio_o),
		.core_divisor_o(core_divisor_o), .core_run_o(core_run_o));
	// System clock, 50 ns period
	always #25 clk_sys_i = ~clk_sys_i;
	// Reference pin toggles every four cycles; rises counted for the lock check
	always @(posedge clk_sys_i) begin
		rdiv <= (rdiv == 3) ? 0 : rdiv + 1;
		if (rdiv == 3) begin
			ref_pin <= ~ref_pin;
			if (!ref_pin) ref_rises <= ref_rises + 1;
		end
	end
	// Compare and count one value
	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Watch read completions and match them against the oldest note
	always @(posedge clk_sys_i) begin
		if (psel && penable && pready_o === 1'b1 && !pwrite) begin
			if (exp_q.size() == 0) check("unexpected_read", 32'h0, 32'h1);
			else begin
				check("prdata", exp_q[0].data, prdata_o);
				check("pslverr", 32'(exp_q[0].err), 32'(pslverr_o));
				void'(exp_q.pop_front());
			end
		end
	end
	// One APB transfer; holds the request until pready is seen high
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_i);
		penable <= 1'b1;
		@(posedge clk_sys_i);
		while (pready_o !== 1'b1 && k < 50) begin
			k++;
			@(posedge clk_sys_i);
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	// Read with the expected answer noted first
	task automatic apb_rd(input logic [7:0] a, input logic [31:0] e, input logic er);
		exp_q.push_back('{e, er});
		apb(a, 1'b0, 32'h0);
	endtask
	function automatic logic [31:0] word(ccr_mult_type m, ccr_divc_type d, logic h, logic l);
		return (32'(l) << LOCK_BIT) | (32'(h) << HALVE_BIT) | (32'(d) << DIV_LSB) | 32'(m);
	endfunction
	function automatic ccr_mult_type strap_mult(int s);
		return (s == 0) ? STRAP_MULT_0 : (s == 1) ? STRAP_MULT_1 :
			(s == 2) ? STRAP_MULT_2 : STRAP_MULT_3;
	endfunction
	function automatic logic smp(bit pc);
		return pc ? periph_clk_o : core_clk_o;
	endfunction
	// Length of one high and the following low phase, in system cycles
	task automatic measure(input bit pc, output int hi, output int lo);
		int k;
		k = 0;
		hi = 0;
		lo = 0;
		do @(posedge clk_sys_i); while (smp(pc) !== 1'b0 && ++k < 200);
		do @(posedge clk_sys_i); while (smp(pc) !== 1'b1 && ++k < 200);
		while (smp(pc) === 1'b1 && k < 400) begin
			hi++;
			k++;
			@(posedge clk_sys_i);
		end
		while (smp(pc) === 1'b0 && k < 400) begin
			lo++;
			k++;
			@(posedge clk_sys_i);
		end
	endtask
	// Reset with given straps, then time the lock wait in reference rises
	task automatic do_reset(input int s);
		int n0, k;
		sys_rst_i <= 1'b1;
		straps <= 2'(s);
		repeat (5) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		n0 = ref_rises;
		k = 0;
		repeat (2) @(posedge clk_sys_i);
		check("core_divisor_reset", 32'h2, 32'(core_divisor_o));
		check("core_run_early", 32'h0, 32'(core_run_o));
		while (core_run_o !== 1'b1 && k < 2000) begin
			k++;
			@(posedge clk_sys_i);
		end
		n0 = ref_rises - n0;
		check("lock_rises", LOCK_SIM, (n0 >= LOCK_SIM - 1 && n0 <= LOCK_SIM) ? LOCK_SIM : n0);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Watchdog well beyond the expected run length
	initial begin
		#2000000;
		err_count++;
		report_and_stop();
	end
	// Main sequence
	initial begin
		ccr_mult_type m;
		int hi, lo, t, old;
		void'($urandom(89214));
		// Straps choose the multiplier across every code
		for (int s = 0; s < 4; s++) begin
			do_reset(s);
			apb_rd(ADDR_STAT, word(strap_mult(s), 2'h0, 1'b0, 1'b1), 1'b0);
			check("vco_strap", 32'(strap_mult(s)) * 2, 32'(vco_ratio_o));
		end
		$display("test strap ratio done");
		// Software multiplier kept small so the oscillator stays in range
		m = 6'($urandom_range(31, 1));
		old = 1;
		for (int c = 0; c < 4; c++) begin
			apb(ADDR_CTRL, 1'b1, word(m, 2'(c), 1'b0, 1'b0));
			for (int i = 0; i < 3; i++) begin
				measure(1'b0, hi, lo);
				t = (hi >= (old < (1 << c) ? old : 1 << c)) && (hi <= (old > (1 << c) ? old : 1 << c));
				check("switch_phase", 32'h1, 32'(t));
			end
			repeat (60) @(posedge clk_sys_i);
			measure(1'b0, hi, lo);
			check("core_high", 1 << c, hi);
			check("core_low", 1 << c, lo);
			measure(1'b1, hi, lo);
			check("periph_high", 2 << c, hi);
			check("periph_low", 2 << c, lo);
			check("core_divisor", 2 << c, 32'(core_divisor_o));
			check("vco_soft", 32'(m) * 2, 32'(vco_ratio_o));
			apb_rd(ADDR_STAT, word(m, 2'(c), 1'b0, 1'b1), 1'b0);
			old = 1 << c;
		end
		$display("test divider done");
		// Loop input ticks: one per reference rise, or one per two when halving
		for (int h = 0; h < 2; h++) begin
			apb(ADDR_CTRL, 1'b1, word(m, 2'h0, 1'(h), 1'b0));
			repeat (40) @(posedge clk_sys_i);
			t = 0;
			repeat (320) begin
				@(posedge clk_sys_i);
				if (loop_input_tick_o === 1'b1) t++;
			end
			check("ticks", 40 >> h, (t >= (40 >> h) - 1 && t <= (40 >> h) + 1) ? 40 >> h : t);
			apb_rd(ADDR_STAT, word(m, 2'h0, 1'(h), 1'b1), 1'b0);
		end
		$display("test halving done");
		// Status is read-only and unmapped places answer with an error
		apb(ADDR_STAT, 1'b1, 32'hFFFFFFFF);
		apb_rd(ADDR_CTRL, word(m, 2'h0, 1'b1, 1'b0), 1'b0);
		apb_rd(8'h08, 32'h0, 1'b1);
		// Mid-run reset hands the ratio back to the straps
		do_reset(3);
		apb_rd(ADDR_CTRL, word(STRAP_MULT_3, DIV_RESET, HALVE_RESET, 1'b0), 1'b0);
		measure(1'b0, hi, lo);
		check("core_high_reset", 32'h1, hi);
		$display("test refusal and reset done");
		report_and_stop();
	end
endmodule
